/* verilog/cdac_pkg.sv */
// Purpose: constants for the two-channel current dac update control
// Assumes: 32-bit classic wishbone slave, 100 MHz clk_i
// Notes:   offsets are byte addresses of aligned words
package cdac_pkg;
  localparam int          CDAC_CHANNELS    = 2;
  localparam int          CDAC_CODE_W      = 8;
  localparam int          CDAC_AMP_W       = 11;
  localparam int          CDAC_ADR_W       = 8;
  // register byte offsets
  localparam logic [7:0]  CDAC_CTL0_OFS    = 8'h00;
  localparam logic [7:0]  CDAC_DATA0_OFS   = 8'h04;
  localparam logic [7:0]  CDAC_CTL1_OFS    = 8'h08;
  localparam logic [7:0]  CDAC_DATA1_OFS   = 8'h0c;
  localparam logic [7:0]  CDAC_STAT_OFS    = 8'h10;
  localparam logic [7:0]  CDAC_OUT_OFS     = 8'h14;
  // control field positions
  localparam int          CDAC_EN_BIT      = 7;
  localparam int          CDAC_SRC_HI      = 6;
  localparam int          CDAC_SRC_LO      = 4;
  localparam int          CDAC_CSC_BIT     = 3;
  localparam int          CDAC_UNUSED_BIT  = 2;
  localparam int          CDAC_FS_HI       = 1;
  localparam int          CDAC_FS_LO       = 0;
  // reset values
  localparam logic [7:0]  CDAC_CTL_RST     = 8'h70;
  localparam logic [7:0]  CDAC_DATA_RST    = 8'h00;
  // update source codes
  localparam logic [2:0]  CDAC_SRC_TMR0    = 3'h0;
  localparam logic [2:0]  CDAC_SRC_TMR3    = 3'h3;
  localparam logic [2:0]  CDAC_SRC_RISE    = 3'h4;
  localparam logic [2:0]  CDAC_SRC_FALL    = 3'h5;
  localparam logic [2:0]  CDAC_SRC_ANY     = 3'h6;
  localparam logic [2:0]  CDAC_SRC_WRITE   = 3'h7;
  // full-scale codes
  localparam logic [1:0]  CDAC_FS_250UA    = 2'h0;
  localparam logic [1:0]  CDAC_FS_500UA    = 2'h1;
  localparam logic [1:0]  CDAC_FS_1MA      = 2'h2;
  localparam logic [1:0]  CDAC_FS_2MA      = 2'h3;
endpackage

/* verilog/cdac_top.sv */
// Purpose: register file and update scheduling of two 8-bit current dacs
// Assumes: timer overflow pulses are on clk_i; strobe pin is asynchronous
// Notes:   amp_o is the output current in steps of 0.25 mA / 256
//
// Notes on behaviour
// R1 - two channels, each with 8-bit code, own control and data register
// R2 - each channel enabled on its own by its control register
// R3 - reference generator on while at least one channel is enabled
// R4 - source field bits 6:4; 111 default, write latches at once
// R5 - codes 000 to 011 hold data until timer 0 to 3 overflows
// R6 - codes 100 to 110 hold data until chosen strobe pin edge
// R7 - 100 rising edge, 101 falling edge, 110 either edge
// R8 - full-scale bits 1:0 give 0.25, 0.5, 1 or 2 mA
// R9 - full scale resets to 0.25 mA
// R10 - output current is code over 256 times full scale
// R11 - enable at control bit 7, one enables the channel
// R12 - several writes before the trigger: only the last is moved
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module cdac_top
  import cdac_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [CDAC_ADR_W-1:0]   adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output      logic [31:0]             dat_o,
  output      logic                    ack_o,
  // update events
  input  wire logic [3:0]              timer_ovf_i,
  input  wire logic                    external_strobe_pin_i,
  // converter side, channel zero
  output      logic                    ch0_enable_o,
  output      logic [CDAC_CODE_W-1:0]  ch0_code_o,
  output      logic [1:0]              ch0_full_scale_o,
  output      logic                    ch0_const_supply_o,
  output      logic [CDAC_AMP_W-1:0]   ch0_amp_o,
  // converter side, channel one
  output      logic                    ch1_enable_o,
  output      logic [CDAC_CODE_W-1:0]  ch1_code_o,
  output      logic [1:0]              ch1_full_scale_o,
  output      logic                    ch1_const_supply_o,
  output      logic [CDAC_AMP_W-1:0]   ch1_amp_o,
  // shared reference current
  output      logic                    ref_on_o
);

  typedef enum logic [1:0]
  {
    CDAC_BUS_IDLE,
    CDAC_BUS_ACK
  } cdac_bus_e;

  cdac_bus_e               bus_state;
  logic [7:0]              ctl       [CDAC_CHANNELS];
  logic [7:0]              data_word [CDAC_CHANNELS];
  logic [7:0]              latch     [CDAC_CHANNELS];
  logic                    pending   [CDAC_CHANNELS];
  logic [CDAC_AMP_W-1:0]   amp       [CDAC_CHANNELS];
  logic                    strobe_meta;
  logic                    strobe_sync;
  logic                    strobe_prev;
  logic                    strobe_rise;
  logic                    strobe_fall;
  logic                    bus_req;
  logic                    wr_take;
  logic                    wr_lane0;
  logic [CDAC_CHANNELS-1:0] ctl_wr;
  logic [CDAC_CHANNELS-1:0] data_wr;
  logic [CDAC_CHANNELS-1:0] trig;
  logic                    ref_on;
  logic [31:0]             next_dat;

  // event selected by the update-source field
  function automatic logic src_event
  (
    input logic [2:0] src,
    input logic [3:0] ovf,
    input logic       rise,
    input logic       fall
  );
    logic ev;
    ev = 1'b0;
    case (src)
      CDAC_SRC_RISE:  ev = rise; // R6 R7
      CDAC_SRC_FALL:  ev = fall; // R6 R7
      CDAC_SRC_ANY:   ev = rise | fall; // R6 R7
      CDAC_SRC_WRITE: ev = 1'b0;
      default:        ev = ovf[src[1:0]]; // R5
    endcase
    return ev;
  endfunction

  // code times full scale, in units of 0.25 mA / 256
  function automatic logic [CDAC_AMP_W-1:0] scale
  (
    input logic [7:0] code,
    input logic [1:0] fs,
    input logic       en
  );
    logic [CDAC_AMP_W-1:0] wide;
    wide = {3'h0, code};
    if (!en)
    begin
      wide = '0;
    end
    return wide << fs; // R8 R10
  endfunction

  // strobe pin synchroniser and edge detect
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end
    else
    begin
      strobe_meta <= external_strobe_pin_i;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
    end
  end

  assign strobe_rise = strobe_sync & ~strobe_prev;
  assign strobe_fall = ~strobe_sync & strobe_prev;

  // bus decode: a write takes effect at the edge that samples ack
  assign bus_req  = cyc_i & stb_i;
  assign wr_take  = bus_req & we_i & ack_o;
  assign wr_lane0 = wr_take & sel_i[0];
  assign ctl_wr[0]  = wr_lane0 && (adr_i == CDAC_CTL0_OFS);
  assign ctl_wr[1]  = wr_lane0 && (adr_i == CDAC_CTL1_OFS);
  assign data_wr[0] = wr_lane0 && (adr_i == CDAC_DATA0_OFS);
  assign data_wr[1] = wr_lane0 && (adr_i == CDAC_DATA1_OFS);

  always_comb
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      trig[i] = src_event(ctl[i][CDAC_SRC_HI:CDAC_SRC_LO], timer_ovf_i,
                          strobe_rise, strobe_fall);
    end
  end

  // bus handshake, one wait state then ack for one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= CDAC_BUS_IDLE;
    end
    else
    begin
      case (bus_state)
        CDAC_BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_state <= CDAC_BUS_ACK;
          end
        end
        CDAC_BUS_ACK:
        begin
          bus_state <= CDAC_BUS_IDLE;
        end
        default:
        begin
          bus_state <= CDAC_BUS_IDLE;
        end
      endcase
    end
  end

  assign ack_o = (bus_state == CDAC_BUS_ACK) & bus_req;

  // control registers
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      if (rst_i)
      begin
        ctl[i] <= CDAC_CTL_RST; // R4 R9
      end
      else if (ctl_wr[i])
      begin
        ctl[i] <= dat_i[7:0] & ~(8'h01 << CDAC_UNUSED_BIT); // R2 R11
      end
    end
  end

  // holding data registers, last write always kept
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      if (rst_i)
      begin
        data_word[i] <= CDAC_DATA_RST;
      end
      else if (data_wr[i])
      begin
        data_word[i] <= dat_i[7:0]; // R1 R12
      end
    end
  end

  // pending flag: a write in the trigger cycle keeps it set
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      if (rst_i)
      begin
        pending[i] <= 1'b0;
      end
      else if (data_wr[i])
      begin
        pending[i] <= (ctl[i][CDAC_SRC_HI:CDAC_SRC_LO] != CDAC_SRC_WRITE);
      end
      else if (trig[i])
      begin
        pending[i] <= 1'b0;
      end
    end
  end

  // input latches
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      if (rst_i)
      begin
        latch[i] <= CDAC_DATA_RST;
      end
      else if (data_wr[i] &&
               ctl[i][CDAC_SRC_HI:CDAC_SRC_LO] == CDAC_SRC_WRITE)
      begin
        latch[i] <= dat_i[7:0]; // R4
      end
      else if (trig[i] && pending[i])
      begin
        latch[i] <= data_word[i]; // R5 R6 R12
      end
    end
  end

  // output current words and reference enable
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CDAC_CHANNELS; i++)
    begin
      if (rst_i)
      begin
        amp[i] <= '0;
      end
      else
      begin
        amp[i] <= scale(latch[i], ctl[i][CDAC_FS_HI:CDAC_FS_LO],
                        ctl[i][CDAC_EN_BIT]); // R10
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_on <= 1'b0;
    end
    else
    begin
      ref_on <= ctl[0][CDAC_EN_BIT] | ctl[1][CDAC_EN_BIT]; // R3
    end
  end

  // read mux, unmapped reads return zero
  always_comb
  begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      CDAC_CTL0_OFS:  next_dat[7:0] = ctl[0];
      CDAC_DATA0_OFS: next_dat[7:0] = data_word[0];
      CDAC_CTL1_OFS:  next_dat[7:0] = ctl[1];
      CDAC_DATA1_OFS: next_dat[7:0] = data_word[1];
      CDAC_STAT_OFS:  next_dat[4:0] = {ref_on, pending[1], pending[0],
                                       ctl[1][CDAC_EN_BIT],
                                       ctl[0][CDAC_EN_BIT]};
      CDAC_OUT_OFS:   next_dat[15:0] = {latch[1], latch[0]};
      default:        next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (bus_req && bus_state == CDAC_BUS_IDLE)
    begin
      dat_o <= next_dat;
    end
  end

  assign ch0_enable_o       = ctl[0][CDAC_EN_BIT]; // R2 R11
  assign ch1_enable_o       = ctl[1][CDAC_EN_BIT]; // R2 R11
  assign ch0_code_o         = latch[0];
  assign ch1_code_o         = latch[1];
  assign ch0_full_scale_o   = ctl[0][CDAC_FS_HI:CDAC_FS_LO]; // R8
  assign ch1_full_scale_o   = ctl[1][CDAC_FS_HI:CDAC_FS_LO]; // R8
  assign ch0_const_supply_o = ctl[0][CDAC_CSC_BIT];
  assign ch1_const_supply_o = ctl[1][CDAC_CSC_BIT];
  assign ch0_amp_o          = amp[0];
  assign ch1_amp_o          = amp[1];
  assign ref_on_o           = ref_on;

endmodule

/* testbench/cduc_props.sv */
// Purpose: port checks of the dac update control
// Assumes: one wait state acks, registered outputs
// Notes:   bound to cdac_top
`timescale 1ns/1ns
module cduc_props
  import cdac_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        ch0_enable_o,
  input wire logic [7:0]  ch0_code_o,
  input wire logic [1:0]  ch0_full_scale_o,
  input wire logic [10:0] ch0_amp_o,
  input wire logic        ch1_enable_o,
  input wire logic [1:0]  ch1_full_scale_o,
  input wire logic        ref_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       wr;
  logic [2:0] src0;
  assign wr = ack_o && we_i && sel_i[0];
  // tracks the update source of channel zero
  always_ff @(posedge clk_i)
    if (rst_i)
      src0 <= 3'h7;
    else if (wr && adr_i == CDAC_CTL0_OFS)
      src0 <= dat_i[6:4];
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_wait_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  ctl0_set_a: assert property (wr && adr_i == CDAC_CTL0_OFS |=>
    ch0_enable_o == $past(dat_i[7]) && ch0_full_scale_o == $past(dat_i[1:0]))
    else $error("control zero not applied");
  ctl1_set_a: assert property (wr && adr_i == CDAC_CTL1_OFS |=>
    ch1_enable_o == $past(dat_i[7]) && ch1_full_scale_o == $past(dat_i[1:0]))
    else $error("control one not applied");
  imm_load_a: assert property (wr && adr_i == CDAC_DATA0_OFS &&
    src0 == 3'h7 |=> ch0_code_o == $past(dat_i[7:0]))
    else $error("write did not load latch");
  amp_map_a: assert property (ch0_amp_o == ($past(ch0_enable_o) ?
    11'($past(ch0_code_o)) << $past(ch0_full_scale_o) : 11'h0))
    else $error("output current wrong");
  read_pad_a: assert property (ack_o && !we_i && adr_i != CDAC_OUT_OFS
    |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ref_gen_a: assert property (
    $stable(ch0_enable_o) && $stable(ch1_enable_o)
    |-> ref_on_o == (ch0_enable_o || ch1_enable_o))
    else $error("reference state wrong");
  cover property (wr && adr_i == CDAC_DATA0_OFS && src0 != 3'h7);
  cover property ($rose(ref_on_o));
  cover property (ack_o && !we_i && adr_i == CDAC_OUT_OFS);
endmodule
bind cdac_top cduc_props chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .dat_o, .ack_o, .ch0_enable_o, .ch0_code_o, .ch0_full_scale_o,
  .ch0_amp_o, .ch1_enable_o, .ch1_full_scale_o, .ref_on_o
);

/* testbench/cduc_events.sv */
// Purpose: timers and strobe pin beside the dac block
// Assumes: overflow pulses last one clock
// Notes:   driven by task calls from the bench
`timescale 1ns/1ns
module cduc_events (
  // clock
  input  wire logic clk_i,
  // update events
  output logic [3:0] timer_ovf_o,
  output logic       strobe_o
);
  initial
  begin
    timer_ovf_o = 4'h0;
    strobe_o = 1'b0;
  end
  task automatic tick(input int n);
    @(posedge clk_i);
    timer_ovf_o <= 4'h1 << n;
    @(posedge clk_i);
    timer_ovf_o <= 4'h0;
  endtask
  task automatic pin(input logic v);
    @(posedge clk_i);
    strobe_o <= v;
  endtask
endmodule

/* testbench/test_current_dac_update_control.sv */
// Purpose: self-checking run of the dac update control
// Assumes: one wait state bus, strobe seen three clocks late
// Notes:   read data checked by a queue monitor
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_current_dac_update_control
  import cdac_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ref_on_o;
  logic [7:0]  adr_i, l0, l1, d;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, e;
  logic [10:0] ch0_amp_o;
  logic [1:0]  ch0_full_scale_o;
  wire  [3:0]  timer_ovf_i;
  wire         external_strobe_pin_i;
  logic [31:0] q[$];
  int          fails, comparisons, seed, n, m;
  cdac_top dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .timer_ovf_i, .external_strobe_pin_i,
    .ch0_enable_o(), .ch0_code_o(), .ch0_full_scale_o,
    .ch0_const_supply_o(), .ch0_amp_o, .ch1_enable_o(),
    .ch1_code_o(), .ch1_full_scale_o(), .ch1_const_supply_o(),
    .ch1_amp_o(), .ref_on_o
  );
  cduc_events ev (.clk_i, .timer_ovf_o(timer_ovf_i),
    .strobe_o(external_strobe_pin_i));
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] v);
    int k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    if (k == 20) fails++;
    @(posedge clk_i);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(0, a, 0);
  endtask
  always @(negedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
      e = q.pop_front();
      `CHK(dat_o, e)
    end
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    results;
  end
  initial
  begin
    seed = 73;
    rst_i = 1;
    cyc_i = 0;
    stb_i = 0;
    we_i = 0;
    adr_i = 0;
    sel_i = 4'hf;
    dat_i = 0;
    l0 = 0;
    l1 = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    rd(CDAC_CTL0_OFS, 32'h70);
    rd(CDAC_CTL1_OFS, 32'h70);
    rd(CDAC_DATA1_OFS, 32'h0);
    rd(8'h20, 32'h0);
    for (n = 0; n < 4; n++)
    begin
      d = 8'($random(seed));
      wb(1, CDAC_CTL0_OFS, 32'hf0 | n);
      wb(1, CDAC_DATA0_OFS, {24'h0, d});
      l0 = d;
      repeat (2) @(negedge clk_i);
      `CHK(ch0_amp_o, 11'(d) << n)
      `CHK(ch0_full_scale_o, 2'(n))
      `CHK(ref_on_o, 1'b1)
    end
    rd(CDAC_OUT_OFS, {16'h0, l1, l0});
    wb(1, CDAC_CTL0_OFS, 32'h74);
    repeat (2) @(negedge clk_i);
    `CHK(ch0_amp_o, 11'h0)
    `CHK(ref_on_o, 1'b0)
    rd(CDAC_CTL0_OFS, 32'h70);
    for (n = 0; n < 4; n++)
    begin
      wb(1, CDAC_CTL1_OFS, 32'h80 | (n << 4));
      wb(1, CDAC_DATA1_OFS, $random(seed) & 32'hff);
      d = 8'($random(seed));
      wb(1, CDAC_DATA1_OFS, {24'h0, d});
      ev.tick((n + 1) % 4);
      rd(CDAC_OUT_OFS, {16'h0, l1, l0});
      ev.tick(n);
      l1 = d;
      rd(CDAC_OUT_OFS, {16'h0, l1, l0});
    end
    for (n = 4; n < 7; n++)
    begin
      wb(1, CDAC_CTL0_OFS, 32'(n << 4));
      for (m = 0; m < 2; m++)
      begin
        d = 8'($random(seed));
        wb(1, CDAC_DATA0_OFS, {24'h0, d});
        ev.pin(!external_strobe_pin_i);
        repeat (6) @(posedge clk_i);
        if (n == 6 || (n == 4) == (external_strobe_pin_i === 1'b1))
          l0 = d;
        rd(CDAC_OUT_OFS, {16'h0, l1, l0});
      end
    end
    `CHK(ref_on_o, 1'b1)
    results;
  end
endmodule
